// File: logic/acc_load_pkg.sv
// Constants for the control-register-to-accumulator transfer group.
// Assumes a 4-bit core with a 10-bit instruction word, clocked per instruction cycle.
// Function
// - Opcode 242h copies serial control register whole into accumulator, one cycle.
// - First wakeup-control read copies wakeup register A into accumulator, one cycle.
// - Opcode 1001011001b copies wakeup register B into accumulator, one cycle.
// - Opcode 1001011010b copies wakeup register C into accumulator, one cycle.
// - Opcode 24Ah copies wakeup register D into accumulator, one cycle.
// - Opcode 1001001001b puts conversion bits 1:0 in accumulator 3:2, zeroes 1:0.
package acc_load_pkg;
    localparam int OPC_W  = 10;
    localparam int ACC_W  = 4;
    localparam int CONV_W = 8;
    localparam int ADDR_W = 4;
    localparam int SEL_W  = 6;

    localparam logic [OPC_W-1:0] OPC_SERIAL = 10'h242;
    localparam logic [OPC_W-1:0] OPC_WAKE_A = 10'h258;
    localparam logic [OPC_W-1:0] OPC_WAKE_B = 10'h259;
    localparam logic [OPC_W-1:0] OPC_WAKE_C = 10'h25a;
    localparam logic [OPC_W-1:0] OPC_WAKE_D = 10'h24a;
    localparam logic [OPC_W-1:0] OPC_CONV   = 10'h249;

    localparam int SEL_SERIAL = 0;
    localparam int SEL_WAKE_A = 1;
    localparam int SEL_WAKE_B = 2;
    localparam int SEL_WAKE_C = 3;
    localparam int SEL_WAKE_D = 4;
    localparam int SEL_CONV   = 5;

    localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_ACC    = 4'h4;
    localparam logic [ADDR_W-1:0] REG_CARRY  = 4'h8;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'hc;

    localparam int CTRL_EXEC_EN_BIT = 0;
    localparam int STAT_LAST_SEL_LO = 0;
    localparam int STAT_EXEC_CNT_LO = 8;
    localparam int EXEC_CNT_W       = 8;

    localparam logic [31:0]      CTRL_RESET  = 32'h0000_0001;
    localparam logic [ACC_W-1:0] ACC_RESET   = 4'h0;
    localparam logic             CARRY_RESET = 1'b0;
endpackage

// File: logic/acc_dec_if.sv
// Carrier between the transfer core and its opcode decoder.
// Assumes both ends share one clock domain; the signals are combinational.
`timescale 1ns/100ps
interface acc_dec_if;
    import acc_load_pkg::*;
    logic [OPC_W-1:0] opcode;
    logic [SEL_W-1:0] sel;
    modport dec  (input opcode, output sel);
    modport core (output opcode, input sel);
endinterface

// File: logic/acc_load_dec.sv
// Opcode decoder for the transfer group: one-hot select per instruction.
// Assumes the opcode is stable for the whole cycle in which it is offered.
`timescale 1ns/100ps
module acc_load_dec (
    acc_dec_if.dec dif
);
    import acc_load_pkg::*;

    always_comb begin
        dif.sel             = '0;
        dif.sel[SEL_SERIAL] = (dif.opcode == OPC_SERIAL);
        dif.sel[SEL_WAKE_A] = (dif.opcode == OPC_WAKE_A);
        dif.sel[SEL_WAKE_B] = (dif.opcode == OPC_WAKE_B);
        dif.sel[SEL_WAKE_C] = (dif.opcode == OPC_WAKE_C);
        dif.sel[SEL_WAKE_D] = (dif.opcode == OPC_WAKE_D);
        dif.sel[SEL_CONV]   = (dif.opcode == OPC_CONV);
    end
endmodule // acc_load_dec

// File: logic/acc_load_core.sv
// Executes the control-register-to-accumulator transfers in one instruction cycle.
// Assumes source registers and opcode come from logic on clk_i; software port is single-cycle.
`timescale 1ns/100ps
module acc_load_core (
    input  wire logic                         clk_i,
    input  wire logic                         reset_n_i,
    input  wire logic                         ce_i,
    input  wire logic                         exec_i,
    input  wire logic [acc_load_pkg::OPC_W-1:0]  opcode_i,
    input  wire logic [acc_load_pkg::ACC_W-1:0]  serial_ctrl_reg_i,
    input  wire logic [acc_load_pkg::ACC_W-1:0]  wake_ctrl_reg_a_i,
    input  wire logic [acc_load_pkg::ACC_W-1:0]  wake_ctrl_reg_b_i,
    input  wire logic [acc_load_pkg::ACC_W-1:0]  wake_ctrl_reg_c_i,
    input  wire logic [acc_load_pkg::ACC_W-1:0]  wake_ctrl_reg_d_i,
    input  wire logic [acc_load_pkg::CONV_W-1:0] conv_result_i,
    input  wire logic [acc_load_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [31:0]                  wr_data_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [31:0]                  rd_data_o,
    output logic      [acc_load_pkg::ACC_W-1:0]  acc_o,
    output logic                              carry_flag_o,
    output logic                              skip_o,
    output logic                              done_o
);
    import acc_load_pkg::*;

    logic [ACC_W-1:0]      acc_reg;
    logic [ACC_W-1:0]      acc_next;
    logic                  carry_flag_reg;
    logic                  skip_reg;
    logic                  done_reg;
    logic                  exec_en_reg;
    logic [SEL_W-1:0]      last_sel_reg;
    logic [EXEC_CNT_W-1:0] exec_cnt_reg;
    logic [31:0]           rd_data_reg;
    logic                  hit;
    logic                  fire;

    // Decoder kept apart so a wider opcode map only touches one file
    acc_dec_if dif ();
    assign dif.opcode = opcode_i;

    acc_load_dec u_dec (
        .dif (dif.dec)
    );

    assign hit  = |dif.sel;
    assign fire = ce_i && exec_i && exec_en_reg && hit;

    // Decoder is one-hot, so the order below never matters
    always_comb begin
        acc_next = acc_reg;
        if (dif.sel[SEL_SERIAL]) begin
            acc_next = serial_ctrl_reg_i;
        end
        if (dif.sel[SEL_WAKE_A]) begin
            acc_next = wake_ctrl_reg_a_i;
        end
        if (dif.sel[SEL_WAKE_B]) begin
            acc_next = wake_ctrl_reg_b_i;
        end
        if (dif.sel[SEL_WAKE_C]) begin
            acc_next = wake_ctrl_reg_c_i;
        end
        if (dif.sel[SEL_WAKE_D]) begin
            acc_next = wake_ctrl_reg_d_i;
        end
        if (dif.sel[SEL_CONV]) begin
            acc_next = {conv_result_i[1:0], 2'b00};
        end
    end

    // Instruction beats a same-cycle software write: the core owns the accumulator
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_reg <= ACC_RESET;
        end else if (ce_i) begin
            if (fire) begin
                acc_reg <= acc_next;
            end else if (wr_i && addr_i == REG_ACC) begin
                acc_reg <= wr_data_i[ACC_W-1:0];
            end
        end
    end

    // Only software touches carry; transfers leave it alone
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            carry_flag_reg <= CARRY_RESET;
        end else if (ce_i && wr_i && addr_i == REG_CARRY) begin
            carry_flag_reg <= wr_data_i[0];
        end
    end

    // These instructions never request a skip
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            skip_reg <= 1'b0;
        end else if (ce_i) begin
            skip_reg <= 1'b0;
        end
    end

    // Pulse holds while ce_i is low, so a stalled pipeline still sees it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_reg <= 1'b0;
        end else if (ce_i) begin
            done_reg <= fire;
        end
    end

    // Enable resets high so code runs without a setup write
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            exec_en_reg <= CTRL_RESET[CTRL_EXEC_EN_BIT];
        end else if (ce_i && wr_i && addr_i == REG_CTRL) begin
            exec_en_reg <= wr_data_i[CTRL_EXEC_EN_BIT];
        end
    end

    // Counter wraps; only a rough activity gauge for software
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_sel_reg <= '0;
            exec_cnt_reg <= '0;
        end else if (ce_i && fire) begin
            last_sel_reg <= dif.sel;
            exec_cnt_reg <= exec_cnt_reg + 8'h01;
        end
    end

    // Read data live for the cycle after the strobe, held longer while ce_i is low
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_reg <= '0;
        end else if (ce_i) begin
            rd_data_reg <= '0;
            if (rd_i) begin
                unique case (addr_i)
                    REG_CTRL:   rd_data_reg <= {31'h0, exec_en_reg};
                    REG_ACC:    rd_data_reg <= {28'h0, acc_reg};
                    REG_CARRY:  rd_data_reg <= {31'h0, carry_flag_reg};
                    REG_STATUS: rd_data_reg <= {16'h0, exec_cnt_reg, 2'b00, last_sel_reg};
                    default:    rd_data_reg <= '0;
                endcase
            end
        end
    end

    assign acc_o        = acc_reg;
    assign carry_flag_o = carry_flag_reg;
    assign skip_o       = skip_reg;
    assign done_o       = done_reg;
    assign rd_data_o    = rd_data_reg;

    AST_SERIAL: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        fire && dif.sel[SEL_SERIAL] |=> acc_o == $past(serial_ctrl_reg_i) && done_o)
        else $error("serial control transfer wrong");

    AST_WAKE_A: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        fire && opcode_i == OPC_WAKE_A |=> acc_o == $past(wake_ctrl_reg_a_i))
        else $error("wakeup A transfer wrong");

    AST_WAKE_B: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && exec_i && exec_en_reg && opcode_i == 10'h259 |=> acc_o == $past(wake_ctrl_reg_b_i))
        else $error("wakeup B transfer wrong");

    AST_WAKE_C: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && exec_i && exec_en_reg && opcode_i == 10'h25a |=> acc_o == $past(wake_ctrl_reg_c_i))
        else $error("wakeup C transfer wrong");

    AST_WAKE_D: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && exec_i && exec_en_reg && opcode_i == 10'h24a |=> acc_o == $past(wake_ctrl_reg_d_i))
        else $error("wakeup D transfer wrong");

    AST_CONV: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && exec_i && exec_en_reg && opcode_i == 10'h249
        |=> acc_o[3:2] == $past(conv_result_i[1:0]) && acc_o[1:0] == 2'b00)
        else $error("conversion bits transfer wrong");

    AST_CARRY_KEPT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        fire && !(wr_i && addr_i == REG_CARRY) |=> $stable(carry_flag_o) && !skip_o)
        else $error("transfer touched carry or skip");

    AST_IDLE_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !ce_i |=> $stable(acc_o) && $stable(done_o))
        else $error("state moved with clock enable low");

    AST_ONE_HOT_SEL: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $onehot0(dif.sel))
        else $error("decoder select not one-hot");

    AST_REFUSED_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && !fire && !(wr_i && addr_i == REG_ACC) |=> $stable(acc_o) && !done_o)
        else $error("refused instruction changed state");

    AST_DISABLED: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && !exec_en_reg |=> !done_o)
        else $error("transfer ran while disabled");

    AST_CARRY_SW_ONLY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(ce_i && wr_i && addr_i == REG_CARRY) |=> $stable(carry_flag_o))
        else $error("carry moved without a software write");

    AST_SKIP_LOW: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !skip_o)
        else $error("skip requested");

    AST_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        fire |=> done_o && last_sel_reg == $past(dif.sel))
        else $error("transfer not finished in one cycle");

    AST_EXEC_COUNT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        fire |=> exec_cnt_reg == $past(exec_cnt_reg) + 8'h01)
        else $error("execution count did not step");

    AST_ACC_WRITE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && !fire && wr_i && addr_i == REG_ACC |=> acc_o == $past(wr_data_i[ACC_W-1:0]))
        else $error("software accumulator write lost");

    AST_RD_IDLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && !rd_i |=> rd_data_o == 32'h0)
        else $error("read data outside its cycle");
endmodule // acc_load_core

// File: dv/accumulator_load_from_ctrl_regs_bench.sv
// Self-checking bench for the control-register-to-accumulator transfer core.
// Assumes acc_load_core on one clock; the bench drives every port itself.
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module accumulator_load_from_ctrl_regs_bench;
    import acc_load_pkg::*;
    logic              clk_i = 1'b0;
    logic              reset_n_i = 1'b0;
    logic              ce_i = 1'b0;
    logic              exec_i = 1'b0;
    logic              wr_i = 1'b0;
    logic              rd_i = 1'b0;
    logic [OPC_W-1:0]  opcode_i = '0;
    logic [ACC_W-1:0]  src [5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    logic [CONV_W-1:0] conv_i = '0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [31:0]       wr_data_i = '0;
    logic [31:0]       rd_data_o;
    logic [ACC_W-1:0]  acc_o;
    logic              carry_flag_o;
    logic              skip_o;
    logic              done_o;
    logic [OPC_W-1:0]  opc [8] = '{OPC_SERIAL, OPC_WAKE_A, OPC_WAKE_B, OPC_WAKE_C,
                                   OPC_WAKE_D, OPC_CONV, 10'h248, 10'h3ff};
    logic [ACC_W-1:0]  acc_m = '0;
    logic              carry_m = 1'b0;
    logic              done_m = 1'b0;
    logic              en_m = 1'b1;
    logic [7:0]        cnt_m = '0;
    logic [5:0]        last_m = '0;
    int                cur_k = 7;
    int                err_count = 0;
    int                n_checks = 0;

    acc_load_core dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .exec_i(exec_i),
        .opcode_i(opcode_i), .serial_ctrl_reg_i(src[0]), .wake_ctrl_reg_a_i(src[1]),
        .wake_ctrl_reg_b_i(src[2]), .wake_ctrl_reg_c_i(src[3]), .wake_ctrl_reg_d_i(src[4]),
        .conv_result_i(conv_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
        .rd_data_o(rd_data_o), .acc_o(acc_o), .carry_flag_o(carry_flag_o), .skip_o(skip_o),
        .done_o(done_o));

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    // Conversion load keeps only two result bits, low half forced to zero
    function automatic logic [ACC_W-1:0] exp_acc(int k);
        return (k == 5) ? {conv_i[1:0], 2'b00} : src[k];
    endfunction

    // Model sees the old inputs before the new NBAs land at this edge
    task automatic step(input bit c, input bit e, input int k);
        logic v;
        @(posedge clk_i);
        v = ce_i & exec_i & en_m & (cur_k < 6);
        if (ce_i) begin
            done_m = v;
            if (v) begin
                acc_m = exp_acc(cur_k);
                cnt_m++;
                last_m = 6'h01 << cur_k;
            end
        end
        ce_i <= c;
        exec_i <= e;
        opcode_i <= opc[k];
        cur_k = k;
        for (int i = 0; i < 5; i++) src[i] <= 4'($urandom);
        conv_i <= 8'($urandom);
        @(negedge clk_i);
        `CHK(acc_o, acc_m)
        `CHK(done_o, done_m)
        `CHK(carry_flag_o, carry_m)
        `CHK(skip_o, 1'b0)
    endtask

    task automatic run(input int n);
        repeat (n) step($urandom % 8 != 0, $urandom % 4 != 0, $urandom % 8);
        step(1'b1, 1'b0, 7);
        step(1'b1, 1'b0, 7);
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        if (a == REG_ACC) acc_m = d[3:0];
        if (a == REG_CARRY) carry_m = d[0];
        if (a == REG_CTRL) en_m = d[0];
    endtask

    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        `CHK(rd_data_o, e)
        @(negedge clk_i);
        `CHK(rd_data_o, 32'h0)
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #400000;
        err_count++;
        finish_test();
    end

    initial begin
        void'($urandom(2044));
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        ce_i <= 1'b1;
        @(negedge clk_i);
        `CHK(({acc_o, carry_flag_o, skip_o, done_o, rd_data_o}), 39'h0)
        reg_rd(REG_CTRL, 32'h1);
        $display("test reset done");
        for (int k = 0; k < 6; k++) step(1'b1, 1'b1, k);
        for (int k = 5; k >= 0; k--) step(1'b1, 1'b1, k);
        run(300);
        $display("test transfers done");
        reg_wr(REG_CARRY, 32'h1);
        reg_rd(REG_CARRY, 32'h1);
        reg_wr(REG_ACC, 32'ha);
        reg_wr(4'h6, 32'hffff_ffff);
        reg_rd(REG_ACC, {28'h0, acc_m});
        reg_rd(4'h2, 32'h0);
        reg_rd(REG_STATUS, {16'h0, cnt_m, 2'b00, last_m});
        run(100);
        $display("test registers done");
        reg_wr(REG_CTRL, 32'h0);
        run(60);
        reg_wr(REG_CTRL, 32'h1);
        run(60);
        reg_rd(REG_STATUS, {16'h0, cnt_m, 2'b00, last_m});
        $display("test enable done");
        finish_test();
    end
endmodule // accumulator_load_from_ctrl_regs_bench
